//--- verilog/mdx_pkg.sv
// Package with constants, types and carriers for the deposit and swap unit.
package mdx_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  // A word is a left and a right half of sixteen positions each.
  localparam int HALF_W = 16;
  localparam int NUM_HALVES = 2;
  localparam int WORD_W = HALF_W * NUM_HALVES;
  localparam int HALF_LEFT = 1;
  localparam int HALF_RIGHT = 0;
  localparam int OPC_W = 8;
  localparam int IDX_W = 3;
  localparam int ADDR_W = 16;
  localparam logic [IDX_W-1:0] IDX_NONE = 3'h0;

  // ----------------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------------
  // Octal 360, 350 and 030 written in hexadecimal.
  localparam logic [OPC_W-1:0] OPC_MASKED_DEPOSIT = 8'hf0;
  localparam logic [OPC_W-1:0] OPC_SWAP = 8'he8;
  localparam logic [OPC_W-1:0] OPC_MASK_LOAD = 8'h18;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEPOSIT_TIME_US = 18;
  localparam int SWAP_TIME_US = 18;
  localparam int MASK_LOAD_TIME_US = 12;
  localparam int TIMER_W = 8;
  // Least times, rounded up to whole clock cycles.
  localparam logic [TIMER_W-1:0] DEPOSIT_CYC =
    TIMER_W'((DEPOSIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] SWAP_CYC =
    TIMER_W'((SWAP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] MASK_LOAD_CYC =
    TIMER_W'((MASK_LOAD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] TIMER_LAST = 8'h01;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [NUM_HALVES-1:0][HALF_W-1:0] mdx_word_t;

  typedef enum logic [1:0] {
    MDX_ALU_PASS_X = 2'h0,
    MDX_ALU_COMP_X = 2'h1,
    MDX_ALU_AND = 2'h2,
    MDX_ALU_PASS_Z = 2'h3
  } mdx_alu_op_t;

  typedef enum logic [1:0] {
    MDX_KIND_DEPOSIT = 2'h0,
    MDX_KIND_SWAP = 2'h1,
    MDX_KIND_MASK_LOAD = 2'h2
  } mdx_kind_t;

  typedef enum logic [11:0] {
    MDX_IDLE = 12'h001,
    MDX_READ = 12'h002,
    MDX_DEP_COMP1 = 12'h004,
    MDX_DEP_MASK = 12'h008,
    MDX_DEP_AND1 = 12'h010,
    MDX_DEP_OR = 12'h020,
    MDX_DEP_AND2 = 12'h040,
    MDX_SWAP_STORE = 12'h080,
    MDX_WRITE = 12'h100,
    MDX_SWAP_ADD = 12'h200,
    MDX_MASK_SET = 12'h400,
    MDX_HOLD = 12'h800
  } mdx_state_t;

  // Instruction handed over by the sequencer.
  typedef struct packed {
    logic [OPC_W-1:0] opcode;
    logic [IDX_W-1:0] idx_sel;
    logic [HALF_W-1:0] idx_val;
    logic [ADDR_W-1:0] addr;
  } mdx_instr_t;

  // Request to core memory.
  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    mdx_word_t wdata;
  } mdx_mem_req_t;

endpackage

//--- verilog/mdx_half_alu.sv
// Bitwise logic unit for one half-word of the accumulator path.
`timescale 1ns/1ps
module mdx_half_alu (
  input wire mdx_pkg::mdx_alu_op_t op, // Operation to apply.
  input wire logic [15:0] x, // Accumulator half.
  input wire logic [15:0] z, // Operand register half.
  output logic [15:0] y // Result half.
);

  // ----------------------------------------------------------------------
  // Bitwise operations
  // ----------------------------------------------------------------------
  // Every position is handled on its own; nothing carries across.
  always_comb begin
    case (op)
      mdx_pkg::MDX_ALU_PASS_X: y = x;
      mdx_pkg::MDX_ALU_COMP_X: y = ~x;
      mdx_pkg::MDX_ALU_AND: y = x & z;
      mdx_pkg::MDX_ALU_PASS_Z: y = z;
      default: y = x;
    endcase
  end

endmodule // mdx_half_alu

//--- verilog/mdx_cycle_timer.sv
// Down counter that sets the total length of an instruction.
`timescale 1ns/1ps
module mdx_cycle_timer (
  input wire logic clk, // Machine clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes the count.
  input wire logic load, // Load the count.
  input wire logic [mdx_pkg::TIMER_W-1:0] load_val, // Cycles to run.
  output logic expired // Last counted cycle reached.
);

  typedef struct packed {
    logic [mdx_pkg::TIMER_W-1:0] cnt;
  } mdx_timer_t;

  mdx_timer_t r;
  mdx_timer_t next_r;

  // ----------------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------------
  // Counts down to zero and stays there until loaded again.
  always_comb begin
    next_r = r;
    if (load) begin
      next_r.cnt = load_val;
    end else if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 8'h01;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // A slow memory that overruns the count ends the wait at once.
  assign expired = (r.cnt <= mdx_pkg::TIMER_LAST);

endmodule // mdx_cycle_timer

//--- verilog/mdx_unit.sv
// Masked deposit, swap and mask load datapath with its step sequencer.
`timescale 1ns/1ps
module mdx_unit (
  input wire logic clk, // Machine clock, 10 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic start, // Begin an instruction, one-cycle pulse.
  input wire mdx_pkg::mdx_instr_t instr, // Instruction fields.
  input wire logic acc_wr, // Load accumulators while idle.
  input wire mdx_pkg::mdx_word_t acc_in, // Value for acc_wr.
  input wire logic mem_ack, // Memory finished the request.
  input wire mdx_pkg::mdx_word_t mem_rdata, // Read data, valid with ack.
  output logic busy, // Instruction in progress.
  output logic done, // Instruction complete, one-cycle pulse.
  output logic reject, // Start refused, one-cycle pulse.
  output mdx_pkg::mdx_word_t acc, // Accumulators.
  output mdx_pkg::mdx_word_t mask, // Mask register.
  output mdx_pkg::mdx_mem_req_t mem // Memory request bundle.
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    mdx_pkg::mdx_state_t st;
    mdx_pkg::mdx_kind_t kind;
    mdx_pkg::mdx_word_t acc;
    mdx_pkg::mdx_word_t a;
    mdx_pkg::mdx_word_t b;
    mdx_pkg::mdx_word_t mbr;
    logic [mdx_pkg::ADDR_W-1:0] ea;
    logic req;
    logic we;
    logic busy;
    logic done;
    logic reject;
  } mdx_core_t;

  mdx_core_t r;
  mdx_core_t next_r;

  mdx_pkg::mdx_alu_op_t acc_op;
  mdx_pkg::mdx_word_t acc_alu;
  logic known_op;
  logic [mdx_pkg::TIMER_W-1:0] run_cyc;
  mdx_pkg::mdx_kind_t start_kind;
  logic timer_load;
  logic timer_expired;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Maps the operation code onto a kind and its total run length.
  always_comb begin
    known_op = 1'b1;
    start_kind = mdx_pkg::MDX_KIND_DEPOSIT;
    run_cyc = mdx_pkg::DEPOSIT_CYC;
    case (instr.opcode)
      mdx_pkg::OPC_MASKED_DEPOSIT: begin
        start_kind = mdx_pkg::MDX_KIND_DEPOSIT;
        run_cyc = mdx_pkg::DEPOSIT_CYC;
      end
      mdx_pkg::OPC_SWAP: begin
        start_kind = mdx_pkg::MDX_KIND_SWAP;
        run_cyc = mdx_pkg::SWAP_CYC;
      end
      mdx_pkg::OPC_MASK_LOAD: begin
        start_kind = mdx_pkg::MDX_KIND_MASK_LOAD;
        run_cyc = mdx_pkg::MASK_LOAD_CYC;
      end
      default: begin
        known_op = 1'b0;
      end
    endcase
  end

  // The timer starts on the same edge that accepts the instruction.
  assign timer_load = start && known_op && (r.st == mdx_pkg::MDX_IDLE);

  // ----------------------------------------------------------------------
  // Accumulator logic
  // ----------------------------------------------------------------------
  // Chooses the operation the accumulators take in the current step.
  always_comb begin
    case (r.st)
      mdx_pkg::MDX_DEP_COMP1: acc_op = mdx_pkg::MDX_ALU_COMP_X;
      mdx_pkg::MDX_DEP_AND1: acc_op = mdx_pkg::MDX_ALU_AND;
      mdx_pkg::MDX_DEP_OR: acc_op = mdx_pkg::MDX_ALU_COMP_X;
      mdx_pkg::MDX_DEP_AND2: acc_op = mdx_pkg::MDX_ALU_AND;
      mdx_pkg::MDX_SWAP_ADD: acc_op = mdx_pkg::MDX_ALU_PASS_Z;
      default: acc_op = mdx_pkg::MDX_ALU_PASS_X;
    endcase
  end

  // One logic unit per half-word; the halves never interact.
  for (genvar h = 0; h < mdx_pkg::NUM_HALVES; h++) begin : g_half
    mdx_half_alu u_alu (
      .op(acc_op),
      .x(r.acc[h]),
      .z(r.a[h]),
      .y(acc_alu[h])
    );
  end

  // Sets the total length of each instruction.
  mdx_cycle_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .load(timer_load),
    .load_val(run_cyc),
    .expired(timer_expired)
  );

  // ----------------------------------------------------------------------
  // Step sequencer
  // ----------------------------------------------------------------------
  // Walks each instruction through its memory and register steps.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.reject = 1'b0;
    next_r.acc = acc_alu;
    case (r.st)
      mdx_pkg::MDX_IDLE: begin
        if (acc_wr) begin
          next_r.acc = acc_in;
        end
        if (start && known_op) begin
          next_r.kind = start_kind;
          // Index modification happens before the read is issued.
          if (instr.idx_sel != mdx_pkg::IDX_NONE) begin
            next_r.ea = instr.addr + instr.idx_val;
          end else begin
            next_r.ea = instr.addr;
          end
          next_r.req = 1'b1;
          next_r.we = 1'b0;
          next_r.busy = 1'b1;
          next_r.st = mdx_pkg::MDX_READ;
        end else if (start) begin
          next_r.reject = 1'b1;
        end
      end
      mdx_pkg::MDX_READ: begin
        if (mem_ack) begin
          next_r.req = 1'b0;
          next_r.mbr = mem_rdata;
          case (r.kind)
            mdx_pkg::MDX_KIND_DEPOSIT: begin
              next_r.st = mdx_pkg::MDX_DEP_COMP1;
            end
            mdx_pkg::MDX_KIND_SWAP: begin
              // The memory word goes to the operand registers first.
              next_r.a = mem_rdata;
              next_r.st = mdx_pkg::MDX_SWAP_STORE;
            end
            default: begin
              next_r.st = mdx_pkg::MDX_MASK_SET;
            end
          endcase
        end
      end
      mdx_pkg::MDX_DEP_COMP1: begin
        next_r.st = mdx_pkg::MDX_DEP_MASK;
      end
      mdx_pkg::MDX_DEP_MASK: begin
        // A normal transfer: the mask replaces the operand registers.
        next_r.a = r.b;
        next_r.st = mdx_pkg::MDX_DEP_AND1;
      end
      mdx_pkg::MDX_DEP_AND1: begin
        next_r.st = mdx_pkg::MDX_DEP_OR;
      end
      mdx_pkg::MDX_DEP_OR: begin
        // Operand registers are not cleared, so the transfer is an OR.
        next_r.a = r.a | r.mbr;
        next_r.st = mdx_pkg::MDX_DEP_AND2;
      end
      mdx_pkg::MDX_DEP_AND2: begin
        // Masked positions carry the accumulator, the rest memory.
        next_r.mbr = acc_alu;
        next_r.req = 1'b1;
        next_r.we = 1'b1;
        next_r.st = mdx_pkg::MDX_WRITE;
      end
      mdx_pkg::MDX_SWAP_STORE: begin
        // Accumulators pass through the buffer into the word just read.
        next_r.mbr = r.acc;
        next_r.req = 1'b1;
        next_r.we = 1'b1;
        next_r.st = mdx_pkg::MDX_WRITE;
      end
      mdx_pkg::MDX_WRITE: begin
        if (mem_ack) begin
          next_r.req = 1'b0;
          next_r.we = 1'b0;
          if (r.kind == mdx_pkg::MDX_KIND_SWAP) begin
            next_r.st = mdx_pkg::MDX_SWAP_ADD;
          end else begin
            next_r.st = mdx_pkg::MDX_HOLD;
          end
        end
      end
      mdx_pkg::MDX_SWAP_ADD: begin
        next_r.st = mdx_pkg::MDX_HOLD;
      end
      mdx_pkg::MDX_MASK_SET: begin
        next_r.b = r.mbr;
        next_r.st = mdx_pkg::MDX_HOLD;
      end
      mdx_pkg::MDX_HOLD: begin
        // Completion waits for the full documented run length.
        if (timer_expired) begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.st = mdx_pkg::MDX_IDLE;
        end
      end
      default: begin
        next_r.req = 1'b0;
        next_r.we = 1'b0;
        next_r.busy = 1'b0;
        next_r.st = mdx_pkg::MDX_IDLE;
      end
    endcase
    // A start that arrives while busy is refused.
    if (start && (r.st != mdx_pkg::MDX_IDLE)) begin
      next_r.reject = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // All state holds while the clock enable is low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r.st <= mdx_pkg::MDX_IDLE;
      r.kind <= mdx_pkg::MDX_KIND_DEPOSIT;
      r.acc <= mdx_pkg::WORD_RESET;
      r.a <= mdx_pkg::WORD_RESET;
      r.b <= mdx_pkg::WORD_RESET;
      r.mbr <= mdx_pkg::WORD_RESET;
      r.ea <= mdx_pkg::ADDR_RESET;
      r.req <= 1'b0;
      r.we <= 1'b0;
      r.busy <= 1'b0;
      r.done <= 1'b0;
      r.reject <= 1'b0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output is a field of the state register.
  assign busy = r.busy;
  assign done = r.done;
  assign reject = r.reject;
  assign acc = r.acc;
  assign mask = r.b;
  assign mem.req = r.req;
  assign mem.we = r.we;
  assign mem.addr = r.ea;
  assign mem.wdata = r.mbr;

endmodule // mdx_unit

//--- sim/mdx_mem_model.sv
// Behavioural core memory that answers the unit's read and write requests.
`timescale 1ns/1ps
module mdx_mem_model (
  input wire logic clk, // Machine clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic slow, // High makes every answer three cycles later.
  input wire mdx_pkg::mdx_mem_req_t mem, // Request from the unit.
  output logic mem_ack, // One-cycle completion pulse.
  output mdx_pkg::mdx_word_t mem_rdata // Read word, valid with the pulse.
);
  mdx_pkg::mdx_word_t store [256];
  int wait_cnt;

  // The store starts with a fixed scrambled pattern.
  initial begin
    for (int i = 0; i < 256; i++) begin
      store[i] = 32'(i) * 32'h9e37_79b1;
    end
  end

  // Answers each request once; read data is scrambled outside the pulse.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_cnt <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem.req && !mem_ack) begin
        if (wait_cnt >= (slow ? 3 : 0)) begin
          wait_cnt <= 0;
          mem_ack <= 1'b1;
          if (mem.we) begin
            store[mem.addr[7:0]] <= mem.wdata;
          end else begin
            mem_rdata <= store[mem.addr[7:0]];
          end
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule // mdx_mem_model

//--- sim/mdx_unit_properties.sv
// Concurrent checks on the ports of the deposit and swap unit.
`timescale 1ns/1ps
module mdx_unit_properties (
  input wire logic clk, // Machine clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic start, // Start pulse.
  input wire mdx_pkg::mdx_instr_t instr, // Instruction fields.
  input wire logic acc_wr, // Accumulator load strobe.
  input wire mdx_pkg::mdx_word_t acc_in, // Accumulator load value.
  input wire logic mem_ack, // Memory completion pulse.
  input wire mdx_pkg::mdx_word_t mem_rdata, // Memory read data.
  input wire logic busy, // Instruction in progress.
  input wire logic done, // Completion pulse.
  input wire logic reject, // Refusal pulse.
  input wire mdx_pkg::mdx_word_t acc, // Accumulators.
  input wire mdx_pkg::mdx_word_t mask, // Mask register.
  input wire mdx_pkg::mdx_mem_req_t mem // Memory request bundle.
);
  logic known, taken;
  logic [7:0] op_l;
  logic [15:0] ea_l;
  mdx_pkg::mdx_word_t a0, rd0, dep_w, want;
  int cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Decode of accepted starts and the expected results.
  assign known = instr.opcode inside {mdx_pkg::OPC_MASKED_DEPOSIT,
    mdx_pkg::OPC_SWAP, mdx_pkg::OPC_MASK_LOAD};
  assign taken = start && ce && !busy && known;
  assign dep_w = (a0 & mask) | (rd0 & ~mask);
  assign want = (op_l == mdx_pkg::OPC_MASKED_DEPOSIT) ? dep_w :
    (op_l == mdx_pkg::OPC_SWAP) ? rd0 : a0;

  // Captures operands at the start and the read, and counts busy cycles.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_l <= 8'h00;
      ea_l <= 16'h0000;
      a0 <= 32'h0000_0000;
      rd0 <= 32'h0000_0000;
      cnt <= 0;
    end else begin
      if (taken) begin
        op_l <= instr.opcode;
        ea_l <= (instr.idx_sel != mdx_pkg::IDX_NONE) ?
          instr.addr + instr.idx_val : instr.addr;
        a0 <= acc_wr ? acc_in : acc;
      end
      if (mem.req && !mem.we && mem_ack) begin
        rd0 <= mem_rdata;
      end
      if (!busy) begin
        cnt <= 0;
      end else if (ce) begin
        cnt <= cnt + 1;
      end
    end
  end

  sequence s_read;
    $rose(mem.req) && !mem.we;
  endsequence
  sequence s_write;
    $rose(mem.req) && mem.we;
  endsequence
  sequence s_ack;
    mem.req && mem_ack;
  endsequence

  done_busy_a: assert property (done |-> !busy && $past(busy))
    else $error("done without a finished busy period");
  reject_cause_a: assert property (reject |-> $past(start) && $past(ce))
    else $error("reject without a start");
  start_accept_a: assert property (taken |=>
    busy && mem.req && !mem.we)
    else $error("known start not taken with a read");
  bad_opcode_a: assert property (
    start && ce && !busy && !known |=> reject && !busy && !mem.req)
    else $error("unknown opcode not refused");
  busy_start_a: assert property (start && ce && busy |=> reject)
    else $error("start while busy not refused");
  req_hold_a: assert property (mem.req && !mem_ack |=> mem.req &&
    $stable(mem.addr) && $stable(mem.we) && $stable(mem.wdata))
    else $error("memory request changed before answer");
  ack_drop_a: assert property (s_ack |=> !mem.req)
    else $error("request not dropped after answer");
  read_addr_a: assert property (s_read |-> mem.addr == ea_l)
    else $error("read address differs from effective address");
  same_addr_a: assert property (s_write |-> mem.addr == ea_l)
    else $error("write address differs from read address");
  dep_data_a: assert property (
    s_write |-> op_l != mdx_pkg::OPC_MASKED_DEPOSIT || mem.wdata == dep_w)
    else $error("deposit wrote a wrong word");
  swap_data_a: assert property (s_write |->
    op_l != mdx_pkg::OPC_SWAP || mem.wdata == a0)
    else $error("swap wrote a wrong word");
  acc_result_a: assert property (done |-> acc == want &&
    (op_l != mdx_pkg::OPC_MASK_LOAD || mask == rd0))
    else $error("wrong register result at done");
  min_time_a: assert property (done |-> cnt >=
    ((op_l == mdx_pkg::OPC_MASK_LOAD) ? 120 : 180))
    else $error("instruction finished too early");
  acc_load_a: assert property (acc_wr && ce && !busy |=> acc == $past(acc_in))
    else $error("accumulator load lost");
endmodule // mdx_unit_properties

bind mdx_unit mdx_unit_properties mdx_unit_properties_i (
  .clk(clk), .rst_b(rst_b), .ce(ce), .start(start), .instr(instr),
  .acc_wr(acc_wr), .acc_in(acc_in), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .busy(busy), .done(done), .reject(reject),
  .acc(acc), .mask(mask), .mem(mem));

//--- sim/testbench.sv
// Self-checking testbench for the deposit, swap and mask load unit.
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("unexpected at %0t ns: got %h, want %h", $time, got, exp); \
    end \
  end
module testbench;
  logic clk, rst_b, ce, start, acc_wr, mem_ack, busy, done, reject;
  logic slow, pause;
  mdx_pkg::mdx_instr_t instr;
  mdx_pkg::mdx_word_t acc_in, mem_rdata, acc, mask, ref_mask, v;
  mdx_pkg::mdx_mem_req_t mem;
  mdx_pkg::mdx_word_t ref_mem [256];
  logic [7:0] ops [3];
  logic [31:0] seed, r1;
  int errors, comparisons, cyc, t0, rej_cnt;

  mdx_unit mdx_unit_i (.clk(clk), .rst_b(rst_b), .ce(ce), .start(start),
    .instr(instr), .acc_wr(acc_wr), .acc_in(acc_in), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .reject(reject),
    .acc(acc), .mask(mask), .mem(mem));
  mdx_mem_model mdx_mem_model_i (.clk(clk), .rst_b(rst_b), .slow(slow),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // Clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cycle count and a ten-cycle clock-enable pause inside a run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ce <= !(pause && cyc - t0 >= 40 && cyc - t0 < 50);
  end

  // Counts refusal pulses.
  always @(negedge clk) begin
    if (reject === 1'b1) begin
      rej_cnt++;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task print_verdict;
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Runs one instruction and checks registers, memory and duration.
  task automatic run(input logic [7:0] op, input logic [2:0] isel,
    input logic [15:0] ival, input logic [15:0] a,
    input mdx_pkg::mdx_word_t val, input logic p, input logic k);
    logic [15:0] ea;
    mdx_pkg::mdx_word_t m, want;
    int n, r0, len;
    ea = (isel != 3'h0) ? a + ival : a;
    m = ref_mem[ea[7:0]];
    want = val;
    len = 120;
    if (op == mdx_pkg::OPC_MASKED_DEPOSIT) begin
      want = (val & ref_mask) | (m & ~ref_mask);
      ref_mem[ea[7:0]] = want;
      len = 180;
    end else if (op == mdx_pkg::OPC_SWAP) begin
      want = m;
      ref_mem[ea[7:0]] = val;
      len = 180;
    end else begin
      ref_mask = m;
    end
    @(posedge clk);
    start <= 1'b1;
    instr <= '{opcode: op, idx_sel: isel, idx_val: ival, addr: a};
    acc_wr <= 1'b1;
    acc_in <= val;
    pause <= p;
    @(posedge clk);
    t0 = cyc;
    r0 = rej_cnt;
    start <= 1'b0;
    acc_wr <= 1'b0;
    n = 0;
    // A second start while busy must be refused once.
    repeat (5) @(posedge clk);
    start <= k;
    @(posedge clk);
    start <= 1'b0;
    while (done !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    `CHECK(cyc - t0 - 1, len + (p ? 10 : 0))
    `CHECK(acc, want)
    `CHECK(mask, ref_mask)
    `CHECK(rej_cnt - r0, int'(k))
    for (int i = 0; i < 256; i++) begin
      `CHECK(mdx_mem_model_i.store[i], ref_mem[i])
    end
  endtask

  // An unknown operation code is refused and starts nothing.
  task automatic bad(input logic [7:0] op);
    @(posedge clk);
    start <= 1'b1;
    instr.opcode <= op;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    `CHECK(reject, 1'b1)
    `CHECK(busy, 1'b0)
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    #3_000_000;
    errors++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    print_verdict;
  end

  // Main sequence: reset, worked example, refusals, random traffic.
  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    instr = '0;
    acc_wr = 1'b0;
    acc_in = '0;
    {slow, pause} = 2'h0;
    {errors, comparisons, cyc, t0, rej_cnt} = '0;
    seed = 32'd70;
    ref_mask = '0;
    ops = '{mdx_pkg::OPC_MASKED_DEPOSIT, mdx_pkg::OPC_SWAP,
      mdx_pkg::OPC_MASK_LOAD};
    for (int i = 0; i < 256; i++) begin
      ref_mem[i] = 32'(i) * 32'h9e37_79b1;
    end
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHECK({busy, done, reject, mem.req}, 4'h0)
    `CHECK(mask, 32'h0000_0000)
    run(mdx_pkg::OPC_SWAP, 3'h0, 16'h0000, 16'h0010, {2{16'h7007}}, 0, 0);
    run(mdx_pkg::OPC_MASK_LOAD, 3'h0, 16'h0000, 16'h0010, '0, 0, 0);
    run(mdx_pkg::OPC_SWAP, 3'h0, 16'h0000, 16'h0011, {2{16'h08fd}}, 0, 0);
    slow = 1'b1;
    run(mdx_pkg::OPC_MASKED_DEPOSIT, 3'h1, 16'h0001, 16'h0010,
      {2{16'h2bc3}}, 1, 1);
    `CHECK(mdx_mem_model_i.store[8'h11], {2{16'h28fb}})
    foreach (ops[i]) begin
      bad(ops[i] ^ 8'h01);
    end
    bad(8'h00);
    for (int j = 0; j < 18; j++) begin
      r1 = xs(seed);
      seed = xs(r1);
      v = seed;
      slow = r1[31];
      run(ops[r1[1:0] % 3], r1[4:2], {8'h00, r1[12:5]}, r1[28:13], v,
        r1[29], r1[30]);
    end
    print_verdict;
  end
endmodule // testbench
